// ==== isf_buf2.sv ====
// two-entry valid/ready buffer for response words
// assumes both sides on one clock; ce_i freezes all state
`timescale 1ns/1ps
`default_nettype none

module isf_buf2 #(
    parameter int W     = 32,
    parameter int DEPTH = 2
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [W-1:0] mem_r [DEPTH];
    logic         wp_r;
    logic         wp_nxt;
    logic         rp_r;
    logic         rp_nxt;
    logic [1:0]   cnt_r;
    logic [1:0]   cnt_nxt;
    logic         push;
    logic         pop;

    generate
        if (DEPTH != 2 || W < 1)
        begin : g_bad_size
            $error("isf_buf2 serves exactly two entries");
        end
    endgenerate

    assign in_ready_o  = (cnt_r != 2'h2);
    assign out_valid_o = (cnt_r != 2'h0);
    assign out_data_o  = mem_r[rp_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb
    begin
        wp_nxt  = push ? ~wp_r : wp_r;
        rp_nxt  = pop ? ~rp_r : rp_r;
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end
        else if (ce_i)
        begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            if (push)
                mem_r[wp_r] <= in_data_i;
        end
    end

endmodule

`default_nettype wire

// ==== isf_frame.sv ====
// device-side spi frame logic of an inertial sensor in data monitor mode
// assumes spi pins come from another domain and samples come from clk_sys_i logic
`timescale 1ns/1ps
`default_nettype none

module isf_frame (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  frame_select_n_i,
    input  wire logic                  sclk_i,
    input  wire logic                  mosi_i,
    output logic                       miso_o,
    output logic                       miso_oe_o,
    input  wire isf_pkg::isf_samples_t live_samples_i,
    input  wire logic                  alarm_i,
    output logic [1:0]                 keep_alive_counter_o,
    output logic                       capture_armed_o,
    output logic                       frame_error_o
);
    import isf_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;

    assign pin_raw = {frame_select_n_i, sclk_i, mosi_i};

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_sync
            always_ff @(posedge clk_sys_i)
            begin
                if (rst_i)
                begin
                    sync1_r[g] <= (g == 2) ? 1'b1 : 1'b0;
                    sync2_r[g] <= (g == 2) ? 1'b1 : 1'b0;
                    sync3_r[g] <= (g == 2) ? 1'b1 : 1'b0;
                end
                else if (ce_i)
                begin
                    sync1_r[g] <= pin_raw[g];
                    sync2_r[g] <= sync1_r[g];
                    sync3_r[g] <= sync2_r[g];
                end
            end
        end
    endgenerate

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic mosi_s;

    assign cs_fall   = sync3_r[2] && !sync2_r[2];
    assign cs_rise   = !sync3_r[2] && sync2_r[2];
    assign sclk_rise = !sync2_r[2] && !sync3_r[1] && sync2_r[1];
    assign sclk_fall = !sync2_r[2] && sync3_r[1] && !sync2_r[1];
    assign mosi_s    = sync2_r[0];

    // ----------------------------------------
    // response buffer
    // ----------------------------------------
    logic        buf_in_ready;
    logic        buf_out_valid;
    logic [31:0] buf_out_data;
    logic        pend_r;
    logic        pend_nxt;
    logic [31:0] pend_word_r;
    logic [31:0] pend_word_nxt;

    isf_buf2 #(
        .W     (FRAME_BITS),
        .DEPTH (2)
    ) u_buf (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (pend_r),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (pend_word_r),
        .out_valid_o (buf_out_valid),
        .out_ready_i (cs_fall),
        .out_data_o  (buf_out_data)
    );

    // ----------------------------------------
    // frame state
    // ----------------------------------------
    logic [31:0]   rx_r;
    logic [31:0]   rx_nxt;
    logic [5:0]    cnt_r;
    logic [5:0]    cnt_nxt;
    logic          last_r;
    logic          last_nxt;
    logic [31:0]   tx_r;
    logic [31:0]   tx_nxt;
    logic          miso_r;
    logic          miso_nxt;
    logic          oe_r;
    logic          oe_nxt;
    logic          armed_r;
    logic          armed_nxt;
    logic [1:0]    alive_r;
    logic [1:0]    alive_nxt;
    logic          err_r;
    logic          err_nxt;
    isf_snapshot_t snap_r;
    isf_snapshot_t snap_nxt;

    // ----------------------------------------
    // frame decode
    // ----------------------------------------
    logic [5:0]  pad_sh;
    logic [31:0] word;
    logic        count_bad;
    logic        crc_bad;
    logic        cmd_bad;
    logic        sel_ok;
    logic [3:0]  sel;
    logic [15:0] data_sel;
    logic [27:0] resp_body;

    always_comb
    begin
        pad_sh = FRAME_CNT - cnt_r;
        word   = rx_r;
        if (cnt_r < FRAME_CNT)
            word = (rx_r << pad_sh) | (last_r ? ((32'h1 << pad_sh) - 32'h1) : 32'h0);
        sel       = word[SEL_LSB +: 4];
        count_bad = (cnt_r != FRAME_CNT);
        crc_bad   = (word[CRC_W-1:0] != isf_crc4(word[FRAME_BITS-1:CRC_W]));
        sel_ok    = !sel[0] || (sel == SEL_TEMP2) || (sel == SEL_FIXED);
        cmd_bad   = (word[FRAME_BITS-1:DATA_LSB] != 16'h0)
                 || (word[MODE_LSB +: 3] != MODE_READ)
                 || word[RSV_BIT]
                 || (word[SYNC_BIT-1:CRC_W] != 3'h0)
                 || !sel_ok;
        case (sel)
            SEL_GYRO_X: data_sel = snap_r.s.gyro_x;
            SEL_GYRO_Y: data_sel = snap_r.s.gyro_y;
            SEL_GYRO_Z: data_sel = snap_r.s.gyro_z;
            SEL_ACC_X:  data_sel = snap_r.s.acc_x;
            SEL_ACC_Y:  data_sel = snap_r.s.acc_y;
            SEL_ACC_Z:  data_sel = snap_r.s.acc_z;
            SEL_TEMP1:  data_sel = snap_r.s.temp1;
            SEL_TEMP2:  data_sel = snap_r.s.temp2;
            SEL_TDIFF:  data_sel = snap_r.tdiff;
            SEL_FIXED:  data_sel = FIXED_WORD;
            default:    data_sel = 16'h0;
        endcase
        resp_body = {data_sel,
                     alarm_i ? FLAG_ALARM : FLAG_OK,
                     ECHO_MODE, sel, word[SYNC_BIT], 1'b0,
                     alive_r};
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        rx_nxt        = rx_r;
        cnt_nxt       = cnt_r;
        last_nxt      = last_r;
        tx_nxt        = tx_r;
        miso_nxt      = miso_r;
        oe_nxt        = oe_r;
        armed_nxt     = armed_r;
        alive_nxt     = alive_r;
        err_nxt       = err_r;
        snap_nxt      = snap_r;
        pend_nxt      = pend_r && !buf_in_ready;
        pend_word_nxt = pend_word_r;

        if (cs_fall)
        begin
            rx_nxt   = 32'h0;
            cnt_nxt  = 6'h0;
            tx_nxt   = buf_out_valid ? buf_out_data : 32'h0;
            miso_nxt = tx_nxt[FRAME_BITS-1];
            oe_nxt   = 1'b1;
            if (armed_r)
            begin
                snap_nxt.s     = live_samples_i;
                snap_nxt.tdiff = live_samples_i.temp1 - live_samples_i.temp2;
            end
        end
        if (sclk_rise)
        begin
            rx_nxt   = {rx_r[FRAME_BITS-2:0], (cnt_r < FRAME_CNT) ? mosi_s : 1'b0};
            last_nxt = mosi_s;
            if (cnt_r != CNT_SAT)
                cnt_nxt = cnt_r + 6'h1;
        end
        if (sclk_fall)
        begin
            tx_nxt   = {tx_r[FRAME_BITS-2:0], 1'b0};
            miso_nxt = tx_nxt[FRAME_BITS-1];
        end
        if (cs_rise)
        begin
            oe_nxt   = 1'b0;
            miso_nxt = 1'b0;
            pend_nxt = 1'b1;
            if (count_bad || crc_bad)
            begin
                pend_word_nxt = SPI_ERR_WORD;
                err_nxt       = 1'b1;
            end
            else if (cmd_bad)
            begin
                pend_word_nxt = CMD_ERR_WORD;
                err_nxt       = 1'b1;
            end
            else
            begin
                pend_word_nxt = {resp_body, isf_crc4(resp_body)};
                err_nxt       = 1'b0;
                armed_nxt     = word[SYNC_BIT];
                alive_nxt     = alive_r + 2'h1;
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rx_r        <= 32'h0;
            cnt_r       <= 6'h0;
            last_r      <= 1'b0;
            tx_r        <= 32'h0;
            miso_r      <= 1'b0;
            oe_r        <= 1'b0;
            armed_r     <= 1'b1;
            alive_r     <= 2'h0;
            err_r       <= 1'b0;
            snap_r      <= '0;
            pend_r      <= 1'b0;
            pend_word_r <= 32'h0;
        end
        else if (ce_i)
        begin
            rx_r        <= rx_nxt;
            cnt_r       <= cnt_nxt;
            last_r      <= last_nxt;
            tx_r        <= tx_nxt;
            miso_r      <= miso_nxt;
            oe_r        <= oe_nxt;
            armed_r     <= armed_nxt;
            alive_r     <= alive_nxt;
            err_r       <= err_nxt;
            snap_r      <= snap_nxt;
            pend_r      <= pend_nxt;
            pend_word_r <= pend_word_nxt;
        end
    end

    assign miso_o               = miso_r;
    assign miso_oe_o            = oe_r;
    assign keep_alive_counter_o = alive_r;
    assign capture_armed_o      = armed_r;
    assign frame_error_o        = err_r;

endmodule

`default_nettype wire

// ==== isf_frame_checker.sv ====
// assertions on the ports of the spi frame logic
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module isf_frame_checker (
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic       ce_i,
    input wire logic       frame_select_n_i,
    input wire logic       sclk_i,
    input wire logic       miso_o,
    input wire logic       miso_oe_o,
    input wire logic [1:0] keep_alive_counter_o,
    input wire logic       capture_armed_o,
    input wire logic       frame_error_o
);
    // ----------------------------------------
    // frame events
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i || !ce_i);
    sequence s_open;
        $fell(frame_select_n_i);
    endsequence
    sequence s_close;
        $rose(frame_select_n_i);
    endsequence
    sequence s_alive_step;
        $changed(keep_alive_counter_o) && !$past(rst_i);
    endsequence

    // ----------------------------------------
    // checks
    // ----------------------------------------
    oe_open_a: assert property (s_open |-> ##[2:6] miso_oe_o)
        else $error("miso not enabled after frame start");
    oe_close_a: assert property (s_close |-> ##[2:7] !miso_oe_o)
        else $error("miso still enabled after frame end");
    alive_wrap_a: assert property (s_alive_step |->
        keep_alive_counter_o == $past(keep_alive_counter_o) + 2'h1)
        else $error("counter did not step by one");
    alive_idle_a: assert property (s_alive_step |-> frame_select_n_i)
        else $error("counter moved inside a frame");
    arm_idle_a: assert property ($changed(capture_armed_o) && !$past(rst_i)
        |-> frame_select_n_i)
        else $error("arm state moved inside a frame");
    err_frame_a: assert property ($rose(frame_error_o)
        |-> $stable(keep_alive_counter_o) && $stable(capture_armed_o))
        else $error("failing frame changed state");
    err_hold_a: assert property (!frame_select_n_i |-> $stable(frame_error_o))
        else $error("error flag moved inside a frame");
    miso_shift_a: assert property (miso_oe_o && $past(miso_oe_o) && $changed(miso_o)
        |-> !sclk_i)
        else $error("miso changed while sclk high");
endmodule
`default_nettype wire

// ==== isf_host_model.sv ====
// spi host model: master side of the frame link, mode 0
// assumes clk_sys_i is the bench clock; sclk half period is 8 clocks
`timescale 1ns/1ps
`default_nettype none
module isf_host_model (
    input  wire logic clk_sys_i,
    input  wire logic miso_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      mosi_o
);
    // ----------------------------------------
    // frame transfer
    // ----------------------------------------
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // commands arrive with their check code already appended
    task automatic xfer(input logic [31:0] c, input int n, output logic [31:0] r);
        r = 32'h0;
        wt(1);
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            mosi_o = (i < 32) ? c[31-i] : 1'b0;
            wt(8);
            sclk_o = 1'b1;
            if (i < 32)
                r[31-i] = miso_i;
            wt(8);
            sclk_o = 1'b0;
        end
        wt(8);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        wt(10);
    endtask
endmodule
`default_nettype wire

// ==== isf_pkg.sv ====
// package of the inertial spi frame logic: frame layout, codes, crc, sample carrier
// assumes a 32-bit msb-first spi frame with a 4-bit check code in the low nibble
package isf_pkg;

    // ----------------------------------------
    // frame layout
    // ----------------------------------------
    localparam int          FRAME_BITS   = 32;
    localparam int          CRC_W        = 4;
    localparam int          COVER_BITS   = FRAME_BITS - CRC_W;
    localparam int          CNT_W        = 6;
    localparam logic [5:0]  FRAME_CNT    = 6'h20;
    localparam logic [5:0]  CNT_SAT      = 6'h21;
    localparam int          SYNC_BIT     = 7;
    localparam int          ALIVE_LSB    = 4;
    localparam int          SEL_LSB      = 8;
    localparam int          RSV_BIT      = 12;
    localparam int          MODE_LSB     = 13;
    localparam int          FLAG_LSB     = 14;
    localparam int          DATA_LSB     = 16;
    localparam int          DATA_W       = 16;

    // ----------------------------------------
    // codes and fixed words
    // ----------------------------------------
    localparam logic [3:0]  CRC_INIT     = 4'ha;
    localparam logic [3:0]  CRC_POLY     = 4'h1;
    localparam logic [2:0]  MODE_READ    = 3'h5;
    localparam logic [31:0] SPI_ERR_WORD = 32'h00000903;
    localparam logic [31:0] CMD_ERR_WORD = 32'h00000a00;
    localparam logic [15:0] FIXED_WORD   = 16'haa55;
    localparam logic [1:0]  FLAG_OK      = 2'h2;
    localparam logic [1:0]  FLAG_ALARM   = 2'h1;
    localparam logic [1:0]  ECHO_MODE    = 2'h2;
    localparam logic [3:0]  SEL_GYRO_X   = 4'h0;
    localparam logic [3:0]  SEL_GYRO_Y   = 4'h2;
    localparam logic [3:0]  SEL_GYRO_Z   = 4'h4;
    localparam logic [3:0]  SEL_ACC_X    = 4'h6;
    localparam logic [3:0]  SEL_ACC_Y    = 4'h8;
    localparam logic [3:0]  SEL_ACC_Z    = 4'ha;
    localparam logic [3:0]  SEL_TEMP1    = 4'hc;
    localparam logic [3:0]  SEL_TEMP2    = 4'hd;
    localparam logic [3:0]  SEL_TDIFF    = 4'he;
    localparam logic [3:0]  SEL_FIXED    = 4'hf;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] gyro_x;
        logic [15:0] gyro_y;
        logic [15:0] gyro_z;
        logic [15:0] acc_x;
        logic [15:0] acc_y;
        logic [15:0] acc_z;
        logic [15:0] temp1;
        logic [15:0] temp2;
    } isf_samples_t;

    typedef struct packed {
        isf_samples_t s;
        logic [15:0]  tdiff;
    } isf_snapshot_t;

    // ----------------------------------------
    // check code, msb first over the covered bits
    // ----------------------------------------
    function automatic logic [3:0] isf_crc4(input logic [27:0] d);
        logic [3:0] c;
        logic       fb;
        c = CRC_INIT;
        for (int i = COVER_BITS - 1; i >= 0; i--)
        begin
            fb = c[3] ^ d[i];
            c  = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
        end
        return c;
    endfunction

endpackage

// ==== tb_isf_frame.sv ====
// bench of the spi frame logic: host model on the link, samples from here
// assumes the host model waits out each frame before returning
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
    $display("unexpected %0t got %h want %h", $time, (a), (b)); end end
module tb_isf_frame;
    import isf_pkg::*;
    logic            clk_sys_i = 1'b0;
    logic            rst_i     = 1'b1;
    logic            ce_i      = 1'b1;
    logic            alarm_i   = 1'b0;
    isf_samples_t    live      = '0;
    isf_samples_t    snap      = '0;
    wire logic       cs_n, sclk, mosi, miso, armed, ferr;
    wire logic [1:0] alive_o;
    logic [1:0]      k         = 2'h0;
    logic [31:0]     pend      = 32'h0;
    logic [31:0]     rsp;
    int              fails, samples_checked, cyc;

    isf_frame i_isf_frame (
        .clk_sys_i            (clk_sys_i),
        .rst_i                (rst_i),
        .ce_i                 (ce_i),
        .frame_select_n_i     (cs_n),
        .sclk_i               (sclk),
        .mosi_i               (mosi),
        .miso_o               (miso),
        .miso_oe_o            (),
        .live_samples_i       (live),
        .alarm_i              (alarm_i),
        .keep_alive_counter_o (alive_o),
        .capture_armed_o      (armed),
        .frame_error_o        (ferr)
    );
    isf_host_model i_isf_host_model (
        .clk_sys_i (clk_sys_i),
        .miso_i    (miso),
        .cs_n_o    (cs_n),
        .sclk_o    (sclk),
        .mosi_o    (mosi)
    );

    // ----------------------------------------
    // clock, timeout, verdict
    // ----------------------------------------
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fails++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // word builders
    // ----------------------------------------
    function automatic logic [3:0] crc(input logic [27:0] d);
        logic [3:0] c;
        c = 4'ha;
        for (int i = 27; i >= 0; i--)
            c = {c[2:0], 1'b0} ^ {3'h0, c[3] ^ d[i]};
        return c;
    endfunction
    function automatic logic [31:0] cmd(input logic [3:0] s, input logic sc);
        logic [27:0] w;
        w = {16'h0, 3'h5, 1'b0, s, sc, 3'h0};
        return {w, crc(w)};
    endfunction
    function automatic logic [31:0] ans(input logic [15:0] d, input logic [3:0] s,
                                        input logic sc);
        logic [27:0] w;
        w = {d, alarm_i ? 2'h1 : 2'h2, 2'h2, s, sc, 1'b0, k};
        return {w, crc(w)};
    endfunction
    function automatic logic [15:0] val(input isf_samples_t v, input logic [3:0] s);
        case (s)
            4'hc:    return v.temp1;
            4'hd:    return v.temp2;
            4'he:    return v.temp1 - v.temp2;
            4'hf:    return 16'haa55;
            default: return v[127 - 8*s -: 16];
        endcase
    endfunction

    // ----------------------------------------
    // link tasks
    // ----------------------------------------
    task automatic do_reset();
        @(posedge clk_sys_i);
        #1 rst_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1 rst_i = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic set_live(input logic [15:0] b);
        for (int j = 0; j < 8; j++)
            live[16*j +: 16] = b + 16'(j) * 16'h0123;
    endtask
    task automatic xf(input logic [31:0] c, input int n, input logic [31:0] nxt);
        int sh;
        sh = (n < 32) ? 32 - n : 0;
        i_isf_host_model.xfer(c, n, rsp);
        `CHK(rsp >> sh, pend >> sh)
        pend = nxt;
    endtask
    task automatic rd(input logic [3:0] s, input logic sc);
        xf(cmd(s, sc), 32, ans(val(snap, s), s, sc));
        k++;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_capture();
        set_live(16'h1000);
        rd(4'hf, 1'b1);
        set_live(16'h2000);
        snap = live;
        rd(4'h0, 1'b0);
        `CHK(armed, 1'b0)
        set_live(16'h3000);
        for (int s = 0; s < 16; s++)
        begin
            alarm_i = (s == 6);
            if (s % 2 == 0 || s > 12)
                rd(4'(s), 1'b0);
        end
        alarm_i = 1'b0;
        `CHK(alive_o, k)
        rd(4'ha, 1'b1);
        `CHK(armed, 1'b1)
        snap = live;
        rd(4'h2, 1'b0);
    endtask
    task automatic t_errors();
        xf(cmd(4'h0, 1'b1) ^ 32'h1, 32, SPI_ERR_WORD);
        `CHK(armed, 1'b0)
        `CHK(ferr, 1'b1)
        rd(4'h4, 1'b0);
        `CHK(ferr, 1'b0)
        xf(cmd(4'hf, 1'b0), 31, SPI_ERR_WORD);
        xf(cmd(4'hf, 1'b0), 33, SPI_ERR_WORD);
        xf(cmd(4'h1, 1'b0), 32, CMD_ERR_WORD);
        `CHK(alive_o, k)
        rd(4'hc, 1'b0);
    endtask
    task automatic t_freeze();
        logic [31:0] keep;
        keep = pend;
        ce_i = 1'b0;
        pend = 32'h0;
        xf(cmd(4'h0, 1'b1), 32, keep);
        `CHK(alive_o, k)
        `CHK(armed, 1'b0)
        ce_i = 1'b1;
        rd(4'h6, 1'b0);
    endtask
    task automatic t_reset();
        xf(cmd(4'h6, 1'b0) ^ 32'h2, 32, 32'h0);
        do_reset();
        `CHK(alive_o, 2'h0)
        `CHK(ferr, 1'b0)
        `CHK(armed, 1'b1)
        k = 2'h0;
        snap = live;
        rd(4'hd, 1'b0);
        rd(4'he, 1'b0);
        rd(4'h8, 1'b0);
    endtask

    initial
    begin
        do_reset();
        t_capture();
        t_errors();
        t_freeze();
        t_reset();
        end_of_test();
    end
endmodule

bind isf_frame isf_frame_checker i_isf_frame_checker (
    .clk_sys_i            (clk_sys_i),
    .rst_i                (rst_i),
    .ce_i                 (ce_i),
    .frame_select_n_i     (frame_select_n_i),
    .sclk_i               (sclk_i),
    .miso_o               (miso_o),
    .miso_oe_o            (miso_oe_o),
    .keep_alive_counter_o (keep_alive_counter_o),
    .capture_armed_o      (capture_armed_o),
    .frame_error_o        (frame_error_o)
);
`default_nettype wire
